// *** rtl/tef_axil_slave.sv ***
`timescale 1ns/1ps
module tef_axil_slave (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [tef_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [tef_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  tef_regbus_if.slv bus
);
  import tef_pkg::*;

  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  assign s_axi_awready_o = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_have_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign bus.wr_en = aw_have_reg && w_have_reg && !bvalid_reg;
  assign bus.wr_addr = awaddr_reg;
  assign bus.wr_data = wdata_reg;
  assign bus.wr_strb = wstrb_reg;
  assign bus.rd_en = s_axi_arvalid_i && !rvalid_reg;
  assign bus.rd_addr = s_axi_araddr_i;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (bus.wr_en) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = bus.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (bus.rd_en) begin
      rvalid_next = 1'b1;
      rdata_next = bus.rd_hit ? bus.rd_data : 32'h0000_0000;
      rresp_next = bus.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : tef_axil_slave

// *** rtl/tef_chan_flags.sv ***
`timescale 1ns/1ps
module tef_chan_flags (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic input_mode_i,
  input wire logic cmp_evt_i,
  input wire logic capture_i,
  input wire logic gen_i,
  input wire logic clr_flag_i,
  input wire logic clr_ocf_i,
  input wire logic capture_read_i,
  output logic evt_o,
  output logic flag_o,
  output logic ocf_o
);
  logic flag_reg, flag_next, ocf_reg, ocf_next;
  logic cap;

  assign flag_o = flag_reg;
  assign ocf_o = ocf_reg;

  always_comb begin
    cap = input_mode_i && (capture_i || gen_i);
    evt_o = cap || (!input_mode_i && (cmp_evt_i || gen_i));
    flag_next = flag_reg && !clr_flag_i && !(input_mode_i && capture_read_i);
    ocf_next = ocf_reg && !clr_ocf_i;
    if (evt_o) begin
      flag_next = 1'b1;
    end
    if (cap && flag_reg) begin
      ocf_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_reg <= 1'b0;
      ocf_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      ocf_reg <= ocf_next;
    end
  end

  sequence s_second_capture;
    input_mode_i && capture_i && flag_reg;
  endsequence

  a_ocf_input_only: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(ocf_reg) |-> $past(input_mode_i && flag_reg))
    else $error("overcapture set without a pending capture");
  a_ocf_on_recapture: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_second_capture |=> ocf_reg && flag_reg)
    else $error("second capture did not set overcapture");
endmodule : tef_chan_flags

// *** rtl/tef_pkg.sv ***
package tef_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int NCH = 4;
  localparam logic [7:0] OFF_ENABLE = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_EVTGEN = 8'h14;
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] MASK_ENABLE = 16'h5F5F;
  localparam logic [15:0] MASK_EVTGEN = 16'h005F;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_UPD = 0;
  localparam int BIT_CH = 1;
  localparam int BIT_TRIG = 6;
  localparam int BIT_UPD_DMA = 8;
  localparam int BIT_CH_DMA = 9;
  localparam int BIT_TRIG_DMA = 14;
  localparam int BIT_CH_OCF = 9;
  // ----------------------------------------
  // Modes and answers
  // ----------------------------------------
  localparam logic [2:0] SMODE_GATED = 3'h5;
  localparam logic [1:0] CAM_EDGE = 2'h0;
  localparam logic [1:0] CAM_DOWN = 2'h1;
  localparam logic [1:0] CAM_UP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tef_pkg

// *** rtl/tef_regbus_if.sv ***
`timescale 1ns/1ps
interface tef_regbus_if;
  logic wr_en;
  logic [tef_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [tef_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slv(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_hit, rd_data, rd_hit);
  modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : tef_regbus_if

// *** rtl/tef_top.sv ***
`timescale 1ns/1ps
module tef_top (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [tef_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [tef_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic cnt_overflow_i,
  input wire logic cnt_underflow_i,
  input wire logic count_down_i,
  input wire logic [1:0] center_align_select_i,
  input wire logic update_disable_i,
  input wire logic update_request_source_i,
  input wire logic chan_dma_select_i,
  input wire logic [2:0] slave_mode_i,
  input wire logic trigger_input_i,
  input wire logic trig_reinit_i,
  input wire logic [tef_pkg::NCH-1:0] ch_input_mode_i,
  input wire logic [tef_pkg::NCH-1:0] ch_match_i,
  input wire logic [tef_pkg::NCH-1:0] ch_cmp_above_reload_i,
  input wire logic [tef_pkg::NCH-1:0] ch_capture_i,
  input wire logic [tef_pkg::NCH-1:0] ch_capture_read_i,
  output logic irq_o,
  output logic upd_dma_req_o,
  output logic [tef_pkg::NCH-1:0] ch_dma_req_o,
  output logic trig_dma_req_o,
  output logic sw_update_o,
  output logic sw_trigger_o,
  output logic [tef_pkg::NCH-1:0] sw_capture_o
);
  import tef_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  tef_regbus_if bus();

  tef_axil_slave u_slave (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .bus(bus.slv)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic [15:0] lane_mask, wr_enable, clr_vec, gen_vec;
  logic [ADDR_W-1:0] wr_word, rd_word;

  always_comb begin
    lane_mask = {{8{bus.wr_strb[1]}}, {8{bus.wr_strb[0]}}};
    wr_word = {bus.wr_addr[ADDR_W-1:2], 2'b00};
    rd_word = {bus.rd_addr[ADDR_W-1:2], 2'b00};
    wr_enable = (bus.wr_en && wr_word == OFF_ENABLE) ? lane_mask : 16'h0000;
    clr_vec = (bus.wr_en && wr_word == OFF_FLAGS) ? (lane_mask & ~bus.wr_data[15:0]) : 16'h0000;
    gen_vec = (bus.wr_en && wr_word == OFF_EVTGEN) ? (lane_mask & bus.wr_data[15:0] & MASK_EVTGEN) : 16'h0000;
    bus.wr_hit = wr_word == OFF_ENABLE || wr_word == OFF_FLAGS || wr_word == OFF_EVTGEN;
    bus.rd_hit = rd_word == OFF_ENABLE || rd_word == OFF_FLAGS || rd_word == OFF_EVTGEN;
  end

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  logic [15:0] enable_reg, enable_next;

  always_comb begin
    enable_next = ((enable_reg & ~wr_enable) | (bus.wr_data[15:0] & wr_enable)) & MASK_ENABLE;
  end

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic trig_prev_reg, trig_prev_next;
  logic trig_edge, trig_set, upd_set, match_ok, wrap_evt;
  logic [NCH-1:0] cmp_evt, ch_evt, ch_flag, ch_ocf;

  always_comb begin
    trig_prev_next = trigger_input_i;
    if (slave_mode_i == SMODE_GATED) begin
      trig_edge = trigger_input_i != trig_prev_reg;
    end else begin
      trig_edge = trigger_input_i && !trig_prev_reg;
    end
    trig_set = trig_edge || gen_vec[BIT_TRIG];
    upd_set = ((cnt_overflow_i || cnt_underflow_i) && !update_disable_i)
      || ((gen_vec[BIT_UPD] || trig_reinit_i) && !update_request_source_i && !update_disable_i);
    case (center_align_select_i)
      CAM_EDGE: match_ok = 1'b1;
      CAM_DOWN: match_ok = count_down_i;
      CAM_UP: match_ok = !count_down_i;
      default: match_ok = 1'b1;
    endcase
    if (center_align_select_i == CAM_EDGE && count_down_i) begin
      wrap_evt = cnt_underflow_i;
    end else begin
      wrap_evt = cnt_overflow_i;
    end
  end

  // ----------------------------------------
  // Channel flags
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign cmp_evt[gi] = (ch_match_i[gi] && match_ok) || (ch_cmp_above_reload_i[gi] && wrap_evt);
      tef_chan_flags u_ch (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .input_mode_i(ch_input_mode_i[gi]),
        .cmp_evt_i(cmp_evt[gi]),
        .capture_i(ch_capture_i[gi]),
        .gen_i(gen_vec[BIT_CH+gi]),
        .clr_flag_i(clr_vec[BIT_CH+gi]),
        .clr_ocf_i(clr_vec[BIT_CH_OCF+gi]),
        .capture_read_i(ch_capture_read_i[gi]),
        .evt_o(ch_evt[gi]),
        .flag_o(ch_flag[gi]),
        .ocf_o(ch_ocf[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Update and trigger flags, requests
  // ----------------------------------------
  logic upd_flag_reg, upd_flag_next, trig_flag_reg, trig_flag_next;
  logic upd_dma_reg, upd_dma_next, trig_dma_reg, trig_dma_next;
  logic [NCH-1:0] ch_dma_reg, ch_dma_next, sw_cap_reg, sw_cap_next;
  logic sw_upd_reg, sw_upd_next, sw_trig_reg, sw_trig_next;
  logic [15:0] status;

  always_comb begin
    upd_flag_next = upd_set || (upd_flag_reg && !clr_vec[BIT_UPD]);
    trig_flag_next = trig_set || (trig_flag_reg && !clr_vec[BIT_TRIG]);
    upd_dma_next = upd_set && enable_reg[BIT_UPD_DMA];
    trig_dma_next = trig_set && enable_reg[BIT_TRIG_DMA];
    for (int i = 0; i < NCH; i++) begin
      ch_dma_next[i] = (chan_dma_select_i ? upd_set : ch_evt[i]) && enable_reg[BIT_CH_DMA+i];
    end
    sw_cap_next = gen_vec[BIT_CH+:NCH] & ch_input_mode_i;
    sw_upd_next = gen_vec[BIT_UPD];
    sw_trig_next = gen_vec[BIT_TRIG];
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_reg <= RST_ENABLE;
      trig_prev_reg <= 1'b0;
      upd_flag_reg <= RST_FLAGS[BIT_UPD];
      trig_flag_reg <= RST_FLAGS[BIT_TRIG];
      upd_dma_reg <= 1'b0;
      trig_dma_reg <= 1'b0;
      ch_dma_reg <= '0;
      sw_cap_reg <= '0;
      sw_upd_reg <= 1'b0;
      sw_trig_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      trig_prev_reg <= trig_prev_next;
      upd_flag_reg <= upd_flag_next;
      trig_flag_reg <= trig_flag_next;
      upd_dma_reg <= upd_dma_next;
      trig_dma_reg <= trig_dma_next;
      ch_dma_reg <= ch_dma_next;
      sw_cap_reg <= sw_cap_next;
      sw_upd_reg <= sw_upd_next;
      sw_trig_reg <= sw_trig_next;
    end
  end

  // ----------------------------------------
  // Outputs and read mux
  // ----------------------------------------
  always_comb begin
    status = {3'b000, ch_ocf, 2'b00, trig_flag_reg, 1'b0, ch_flag, upd_flag_reg};
    if (rd_word == OFF_ENABLE) begin
      bus.rd_data = {16'h0000, enable_reg};
    end else if (rd_word == OFF_FLAGS) begin
      bus.rd_data = {16'h0000, status};
    end else begin
      bus.rd_data = 32'h0000_0000;
    end
  end

  assign irq_o = |(status[BIT_TRIG:BIT_UPD] & enable_reg[BIT_TRIG:BIT_UPD]);
  assign upd_dma_req_o = upd_dma_reg;
  assign trig_dma_req_o = trig_dma_reg;
  assign ch_dma_req_o = ch_dma_reg;
  assign sw_update_o = sw_upd_reg;
  assign sw_trigger_o = sw_trig_reg;
  assign sw_capture_o = sw_cap_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_sw_trig_write;
    bus.wr_en && wr_word == OFF_EVTGEN && bus.wr_strb[0] && bus.wr_data[BIT_TRIG];
  endsequence

  sequence s_trig_raised;
    trig_flag_reg && sw_trigger_o;
  endsequence

  sequence s_upd_gen_write;
    bus.wr_en && wr_word == OFF_EVTGEN && bus.wr_strb[0] && bus.wr_data[BIT_UPD];
  endsequence

  a_upd_dma_gate: assert property (upd_set |=> upd_dma_req_o == $past(enable_reg[BIT_UPD_DMA]))
    else $error("update dma not gated by its enable");
  a_irq_upd_on: assert property (upd_flag_reg && enable_reg[BIT_UPD] |-> irq_o)
    else $error("update interrupt missing");
  a_irq_quiet: assert property (enable_reg[BIT_TRIG:BIT_UPD] == 7'h00 |-> !irq_o)
    else $error("interrupt without enable");
  a_flag_w1_keep: assert property (upd_flag_reg && bus.wr_en && wr_word == OFF_FLAGS
    && bus.wr_strb[0] && bus.wr_data[BIT_UPD] |=> upd_flag_reg)
    else $error("writing one cleared a flag");
  a_set_wins: assert property (upd_set && clr_vec[BIT_UPD] |=> upd_flag_reg)
    else $error("clear beat a set");
  a_trig_gated: assert property (slave_mode_i == SMODE_GATED && $fell(trigger_input_i) |=> trig_flag_reg)
    else $error("falling edge in gated mode missed");
  a_sw_trig_evt: assert property (s_sw_trig_write |=> s_trig_raised ##1 !sw_trigger_o)
    else $error("trigger generation misbehaved");
  a_upd_src_block: assert property (gen_vec[BIT_UPD] && update_request_source_i && !upd_flag_reg
    && !cnt_overflow_i && !cnt_underflow_i |=> !upd_flag_reg)
    else $error("software update set flag with request source set");
  a_ch_dma_sel: assert property (chan_dma_select_i && upd_set && enable_reg[BIT_CH_DMA]
    |=> ch_dma_req_o[0])
    else $error("channel dma not following update");
  a_evtgen_zero: assert property (bus.rd_en && rd_word == OFF_EVTGEN |=> s_axi_rdata_o == 32'h0000_0000)
    else $error("generation register read nonzero");
  a_sw_upd_pulse: assert property (s_upd_gen_write |=> sw_update_o ##1 !sw_update_o)
    else $error("update generation pulse missing");
  a_trig_dma_gate: assert property (trig_set |=> trig_dma_req_o == $past(enable_reg[BIT_TRIG_DMA]))
    else $error("trigger dma not gated by its enable");
  a_irq_trig_on: assert property (trig_flag_reg && enable_reg[BIT_TRIG] |-> irq_o)
    else $error("trigger interrupt missing");
  a_upd_disabled: assert property (update_disable_i && !upd_flag_reg |=> !upd_flag_reg)
    else $error("update flag set while updates disabled");
  a_reinit_upd: assert property (trig_reinit_i && !update_request_source_i && !update_disable_i
    |=> upd_flag_reg)
    else $error("trigger reinit did not set update flag");
  a_cmp_match_flag: assert property (!ch_input_mode_i[0] && ch_match_i[0] && center_align_select_i == CAM_EDGE
    |=> ch_flag[0])
    else $error("compare match did not set channel flag");
  a_wrap_flag: assert property (ch_cmp_above_reload_i[0] && !ch_input_mode_i[0]
    && !count_down_i && cnt_overflow_i |=> ch_flag[0])
    else $error("wrap with compare above reload did not set flag");
  a_no_out_capture: assert property (gen_vec[BIT_CH] && !ch_input_mode_i[0] |=> !sw_capture_o[0])
    else $error("capture pulse for an output channel");
endmodule : tef_top

// *** sim/tef_dma_model.sv ***
`timescale 1ns/1ps
module tef_dma_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic upd_req_i,
  input wire logic [tef_pkg::NCH-1:0] ch_req_i,
  input wire logic trig_req_i,
  output logic [23:0] cnt_o
);
  import tef_pkg::*;
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  // One transfer served per request pulse
  always_comb begin
    cnt_next = cnt_reg;
    cnt_next[7:0] = cnt_reg[7:0] + {7'h00, upd_req_i};
    cnt_next[15:8] = cnt_reg[15:8] + 8'($countones(ch_req_i));
    cnt_next[23:16] = cnt_reg[23:16] + {7'h00, trig_req_i};
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 24'h000000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign cnt_o = cnt_reg;
endmodule : tef_dma_model

// *** sim/tef_top_test.sv ***
`timescale 1ns/1ps
module tef_top_test;
  import tef_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, upd_dma, trig_dma;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ch_dma;
  logic [8:0] lv = 9'h000;
  logic [14:0] pv = 15'h0000;
  logic [23:0] cnt;
  logic sw_upd, sw_trig;
  logic [3:0] sw_cap;
  logic [11:0] sw_cnt = 12'h000;
  int n_mismatch = 0;
  int compares = 0;

  always #2 clk = ~clk;

  tef_top u_dut (
    .core_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .cnt_overflow_i(pv[0]),
    .cnt_underflow_i(pv[1]), .count_down_i(lv[3]),
    .center_align_select_i(lv[4] ? (lv[8] ? CAM_UP : CAM_DOWN) : CAM_EDGE),
    .update_disable_i(lv[0]), .update_request_source_i(lv[1]), .chan_dma_select_i(lv[2]),
    .slave_mode_i(lv[5] ? SMODE_GATED : 3'h0), .trigger_input_i(lv[6]), .trig_reinit_i(pv[2]),
    .ch_input_mode_i({4{lv[7]}}), .ch_match_i(pv[6:3]), .ch_cmp_above_reload_i({4{lv[8]}}),
    .ch_capture_i(pv[10:7]), .ch_capture_read_i(pv[14:11]), .irq_o(irq), .upd_dma_req_o(upd_dma),
    .ch_dma_req_o(ch_dma), .trig_dma_req_o(trig_dma), .sw_update_o(sw_upd), .sw_trigger_o(sw_trig),
    .sw_capture_o(sw_cap)
  );

  tef_dma_model u_dma (
    .core_clk_i(clk), .rstn_i(rstn), .upd_req_i(upd_dma), .ch_req_i(ch_dma), .trig_req_i(trig_dma), .cnt_o(cnt)
  );

  // Software event pulses seen: capture, trigger, update
  always @(posedge clk) begin
    if (rstn) begin
      sw_cnt <= sw_cnt + {4'($countones(sw_cap)), 3'h0, sw_trig, 3'h0, sw_upd};
    end
  end

  // ----------------------------------------
  // Bus and event tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic h1, h2, h3, dn;
    logic [1:0] r;
    logic [31:0] q;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    dn = 1'b0;
    while (!dn) begin
      @(negedge clk);
      h1 = awvalid && awready;
      h2 = wvalid && wready;
      h3 = arvalid && arready;
      dn = w ? bvalid : rvalid;
      r = w ? bresp : rresp;
      q = rdata;
      @(posedge clk);
      if (h1) awvalid <= 1'b0;
      if (h2) wvalid <= 1'b0;
      if (h3) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    // Idle edge between transfers
    @(posedge clk);
    chk("resp", {29'h0, 1'b1, er}, {29'h0, dn, r});
    if (!w) chk("rdata", d, q);
  endtask : xf

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    xf(1'b1, a, d, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    xf(1'b0, a, d, er);
  endtask : rd

  task automatic pulse(input logic [14:0] ev);
    pv <= ev;
    @(posedge clk);
    pv <= 15'h0000;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic ci(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk);
  endtask : ci

  task automatic st(input logic [8:0] l, input logic [14:0] ev, input logic [6:0] g, input logic [15:0] ex,
                    input logic cl);
    lv <= l;
    pulse(ev);
    if (g != 7'h00) wr(OFF_EVTGEN, {25'h0, g});
    rd(OFF_FLAGS, {16'h0, ex});
    if (cl) wr(OFF_FLAGS, 32'h0);
  endtask : st

  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_ENABLE, 32'h0);
    rd(OFF_FLAGS, 32'h0);
    rd(OFF_EVTGEN, 32'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hFFFF, RESP_SLVERR);
    wr(OFF_ENABLE, 32'hFFFF_FFFF);
    rd(OFF_ENABLE, 32'h5F5F);
    pulse(15'h0001);
    ci(1'b1);
    wr(OFF_FLAGS, 32'hFFFF);
    rd(OFF_FLAGS, 32'h1);
    wr(OFF_FLAGS, 32'hFFFE);
    rd(OFF_FLAGS, 32'h0);
    ci(1'b0);
    st(9'h001, 15'h0003, 7'h00, 16'h0000, 1'b0);
    st(9'h000, 15'h0002, 7'h00, 16'h0001, 1'b1);
    st(9'h002, 15'h0004, 7'h01, 16'h0000, 1'b0);
    st(9'h000, 15'h0000, 7'h01, 16'h0001, 1'b1);
    st(9'h000, 15'h0004, 7'h00, 16'h0001, 1'b1);
    rd(OFF_EVTGEN, 32'h0);
    st(9'h040, 15'h0000, 7'h00, 16'h0040, 1'b1);
    st(9'h000, 15'h0000, 7'h00, 16'h0000, 1'b1);
    st(9'h060, 15'h0000, 7'h00, 16'h0040, 1'b1);
    st(9'h020, 15'h0000, 7'h00, 16'h0040, 1'b1);
    st(9'h000, 15'h0000, 7'h40, 16'h0040, 1'b1);
    st(9'h000, 15'h0078, 7'h00, 16'h001E, 1'b1);
    st(9'h010, 15'h0008, 7'h00, 16'h0000, 1'b1);
    st(9'h018, 15'h0008, 7'h00, 16'h0002, 1'b1);
    st(9'h110, 15'h0008, 7'h00, 16'h0002, 1'b1);
    st(9'h118, 15'h0008, 7'h00, 16'h0000, 1'b1);
    st(9'h000, 15'h0000, 7'h1E, 16'h001E, 1'b1);
    st(9'h100, 15'h0001, 7'h00, 16'h001F, 1'b1);
    st(9'h004, 15'h0001, 7'h00, 16'h0001, 1'b1);
    st(9'h080, 15'h0080, 7'h00, 16'h0002, 1'b0);
    st(9'h080, 15'h0080, 7'h00, 16'h0202, 1'b0);
    st(9'h080, 15'h0800, 7'h00, 16'h0200, 1'b1);
    st(9'h080, 15'h0000, 7'h02, 16'h0002, 1'b0);
    st(9'h080, 15'h0000, 7'h02, 16'h0202, 1'b1);
    st(9'h000, 15'h0008, 7'h00, 16'h0002, 1'b0);
    st(9'h000, 15'h0008, 7'h00, 16'h0002, 1'b1);
    wr(OFF_ENABLE, 32'h0);
    pulse(15'h0079);
    ci(1'b0);
    wr(OFF_ENABLE, 32'h1);
    ci(1'b1);
    rd(OFF_FLAGS, 32'h1F);
    chk("dma", 32'h0004_1806, {8'h00, cnt});
    chk("sw", 32'h0000_0212, {20'h0, sw_cnt});
    summarize();
  end
endmodule : tef_top_test
